// ### src/dcrx_pkg.sv
// Constants, field layout and types of the correction packet receiver.
// Assumes a 200 MHz core clock and a 64 ns serial clock period.
package dcrx_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned REF_PERIOD_NS  = 5;
  localparam int unsigned LINK_PERIOD_NS = 64;
  localparam int unsigned IDLE_PERIODS   = 172;
  // Strictly more than the idle span, so floor plus one cycle
  localparam int unsigned IDLE_CYC_I =
    (IDLE_PERIODS * LINK_PERIOD_NS) / REF_PERIOD_NS + 1;
  localparam logic [11:0] IDLE_CYC = 12'(IDLE_CYC_I);

  // ****************************************************************
  // Packet layout
  // ****************************************************************
  localparam logic [4:0] LAST_BIT = 5'h1d;
  localparam logic [5:0] HDR_6BIT = 6'h27;
  localparam int HDR_LSB   = 24;
  localparam int PAR_LSB   = 20;
  localparam int ADDR_LSB  = 10;
  localparam int LEN_LSB   = 0;
  localparam int DC_C_LSB  = 20;
  localparam int DC_B_LSB  = 10;
  localparam int DC_A_LSB  = 0;
  localparam int CHK_C_LSB = 26;
  localparam int CHK_B_LSB = 16;
  localparam int CHK_A_LSB = 6;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_GS_A = 8'h04;
  localparam logic [7:0] OFS_GS_B = 8'h08;
  localparam logic [7:0] OFS_GS_C = 8'h0c;
  localparam logic [7:0] OFS_DC   = 8'h10;
  localparam logic [7:0] OFS_PKT  = 8'h14;
  localparam int FLG_LSB   = 16;
  localparam int DCV_BIT   = 18;
  localparam logic [9:0] POS_RST = 10'h000;
  localparam logic [9:0] GS_RST  = 10'h000;
  localparam logic [5:0] DC_RST  = 6'h3f;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_HUNT, ST_PRE, ST_DATA, ST_SKIP} dcrx_state_t;

  function automatic logic odd_ones(input logic [9:0] v);
    return ^v;
  endfunction

endpackage

// ### src/dcrx_link.sv
// Serial link capture, clocked by the serial clock itself.
// Assumes data is stable around the rising serial clock edge.
`timescale 1ns/1ps
module dcrx_link
  import dcrx_pkg::*;
(
  // Link
  input  wire logic serial_clock_in,
  input  wire logic rst_in,
  input  wire logic serial_data_in,
  // Towards core domain
  output logic      bit_out,
  output logic      toggle_out
);

  logic bit_r;
  logic bit_nxt;
  logic tog_r;
  logic tog_nxt;

  // Each rising edge flips the toggle; the bit stays put for a full link period,
  // long enough for the core to pick it up behind the toggle sync.
  always_comb begin
    bit_nxt = serial_data_in;
    tog_nxt = ~tog_r;
  end

  always_ff @(posedge serial_clock_in or posedge rst_in) begin
    if (rst_in) begin
      bit_r <= 1'b0;
      tog_r <= 1'b0;
    end else begin
      bit_r <= bit_nxt;
      tog_r <= tog_nxt;
    end
  end

  assign bit_out    = bit_r;
  assign toggle_out = tog_r;

endmodule // dcrx_link

// ### src/dcrx_pwm.sv
// One corrected PWM channel driven from a shared 10-bit period counter.
// Assumes the counter is on the same core clock.
`timescale 1ns/1ps
module dcrx_pwm
  import dcrx_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  // Levels
  input  wire logic [9:0] cnt_in,
  input  wire logic [9:0] gray_in,
  input  wire logic [5:0] dc_in,
  // Output, high while the channel sinks current
  output logic            on_out
);

  logic [9:0] corr_r;
  logic [9:0] corr_nxt;
  logic       on_r;
  logic       on_nxt;

  function automatic logic [9:0] scale(input logic [9:0] g,
                                       input logic [5:0] d);
    logic [15:0] prod;
    prod = g * (16'({1'b0, d}) + 16'h0001);
    return prod[15:6];
  endfunction

  // New duty only at period wrap, so a period never mixes two values
  always_comb begin
    corr_nxt = corr_r;
    if (cnt_in == 10'h3ff)
      corr_nxt = scale(gray_in, dc_in);
    on_nxt = (cnt_in < corr_r);
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      corr_r <= 10'h000;
      on_r   <= 1'b0;
    end else begin
      corr_r <= corr_nxt;
      on_r   <= on_nxt;
    end
  end

  assign on_out = on_r;

  AST_DUTY_SCALE: assert property (
    @(posedge ref_clk_in) disable iff (rst_in)
    cnt_in == 10'h3ff |=> corr_r == $past(scale(gray_in, dc_in)) ##1
      on_out == (($past(cnt_in)) < corr_r))
    else $error("corrected duty not applied");

endmodule // dcrx_pwm

// ### src/dcrx_top.sv
// Correction packet receiver with AXI4-Lite registers and three PWM sinks.
// Assumes the serial clock stops between packets and runs at 64 ns.
`timescale 1ns/1ps
module dcrx_top
  import dcrx_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  // Serial link
  input  wire logic        serial_clock_in,
  input  wire logic        serial_data_in,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // Sink outputs, high while sinking
  output logic             sink_output_a_out,
  output logic             sink_output_b_out,
  output logic             sink_output_c_out
);

  // ****************************************************************
  // Link domain and crossing
  // ****************************************************************
  logic        link_bit;
  logic        link_tog;
  logic [2:0]  tog_s_r;
  logic [2:0]  tog_s_nxt;
  logic [1:0]  sdi_s_r;
  logic [1:0]  sdi_s_nxt;
  logic        bit_evt;

  dcrx_link u_link (
    .serial_clock_in (serial_clock_in),
    .rst_in          (rst_in),
    .serial_data_in  (serial_data_in),
    .bit_out         (link_bit),
    .toggle_out      (link_tog)
  );

  always_comb begin
    tog_s_nxt = {tog_s_r[1:0], link_tog};
    sdi_s_nxt = {sdi_s_r[0], serial_data_in};
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tog_s_r <= 3'h0;
      sdi_s_r <= 2'h0;
    end else begin
      tog_s_r <= tog_s_nxt;
      sdi_s_r <= sdi_s_nxt;
    end
  end

  // link_bit is read only on the event; it changed on the same serial edge as the toggle
  assign bit_evt = tog_s_r[2] ^ tog_s_r[1];

  // ****************************************************************
  // Packet framing and checking
  // ****************************************************************
  dcrx_state_t st_r;
  dcrx_state_t st_nxt;
  logic [11:0] idle_cnt_r;
  logic [11:0] idle_cnt_nxt;
  logic [4:0]  bit_cnt_r;
  logic [4:0]  bit_cnt_nxt;
  logic [9:0]  word_idx_r;
  logic [9:0]  word_idx_nxt;
  logic [29:0] sh_r;
  logic [29:0] sh_nxt;
  logic [9:0]  len_r;
  logic [9:0]  len_nxt;
  logic [5:0]  dc_a_r;
  logic [5:0]  dc_a_nxt;
  logic [5:0]  dc_b_r;
  logic [5:0]  dc_b_nxt;
  logic [5:0]  dc_c_r;
  logic [5:0]  dc_c_nxt;
  logic        dc_valid_r;
  logic        dc_valid_nxt;
  logic [2:0]  flg_r;
  logic [2:0]  flg_nxt;
  logic [2:0]  flg_set;
  logic [2:0]  stat_clr;
  logic [9:0]  ctrl_pos_r;
  logic [29:0] word_w;
  logic        word_done;
  logic        hdr_ok;
  logic        plow_ok;
  logic        p3_ok;
  logic        chk_ok;
  logic        own_w;
  logic        idle_hit;

  assign word_w    = {sh_r[28:0], link_bit};
  assign word_done = bit_evt && bit_cnt_r == LAST_BIT &&
                     (st_r == ST_PRE || st_r == ST_DATA);
  assign hdr_ok  = word_w[HDR_LSB +: 6] == HDR_6BIT;
  assign plow_ok =
    word_w[PAR_LSB]     == odd_ones(word_w[LEN_LSB +: 10]) &&
    word_w[PAR_LSB + 1] == odd_ones(word_w[ADDR_LSB +: 10]) &&
    word_w[PAR_LSB + 2] == odd_ones({4'h0, word_w[HDR_LSB +: 6]});
  assign p3_ok = word_w[PAR_LSB + 3] ==
                 odd_ones({7'h00, word_w[PAR_LSB +: 3]});
  assign chk_ok = word_w[CHK_C_LSB +: 4] == 4'h0 &&
                  word_w[CHK_B_LSB +: 4] == 4'h0 &&
                  word_w[CHK_A_LSB +: 4] == 4'h0;
  // Words arrive last device first, so ours is index length minus position
  assign own_w = st_r == ST_DATA &&
                 word_idx_r == len_r - ctrl_pos_r;
  assign idle_hit = idle_cnt_r == IDLE_CYC - 12'h001 &&
                    !bit_evt && !sdi_s_r[1];

  always_comb begin
    st_nxt       = st_r;
    bit_cnt_nxt  = bit_cnt_r;
    word_idx_nxt = word_idx_r;
    sh_nxt       = sh_r;
    len_nxt      = len_r;
    dc_a_nxt     = dc_a_r;
    dc_b_nxt     = dc_b_r;
    dc_c_nxt     = dc_c_r;
    dc_valid_nxt = dc_valid_r;
    flg_set      = 3'h0;
    idle_cnt_nxt = idle_cnt_r;
    // Any rising clock edge or a high data line restarts the idle span
    if (bit_evt || sdi_s_r[1])
      idle_cnt_nxt = 12'h000;
    else if (idle_cnt_r != IDLE_CYC)
      idle_cnt_nxt = idle_cnt_r + 12'h001;
    if (idle_hit) begin
      st_nxt       = ST_PRE;
      bit_cnt_nxt  = 5'h00;
      word_idx_nxt = 10'h000;
    end else if (bit_evt && (st_r == ST_PRE || st_r == ST_DATA)) begin
      sh_nxt      = word_w;
      bit_cnt_nxt = (bit_cnt_r == LAST_BIT) ? 5'h00 : bit_cnt_r + 5'h01;
    end
    if (word_done && !idle_hit) begin
      if (st_r == ST_PRE) begin
        if (!hdr_ok)
          flg_set[0] = 1'b1;
        if (!(plow_ok && p3_ok))
          flg_set[1] = 1'b1;
        if (hdr_ok && plow_ok && p3_ok) begin
          len_nxt = word_w[LEN_LSB +: 10];
          st_nxt  = ST_DATA;
        end else begin
          st_nxt = ST_SKIP;
        end
      end else begin
        if (own_w && chk_ok) begin
          dc_c_nxt     = word_w[DC_C_LSB +: 6];
          dc_b_nxt     = word_w[DC_B_LSB +: 6];
          dc_a_nxt     = word_w[DC_A_LSB +: 6];
          dc_valid_nxt = 1'b1;
        end else if (own_w) begin
          flg_set[2] = 1'b1;
        end
        if (word_idx_r == len_r)
          st_nxt = ST_SKIP;
        else
          word_idx_nxt = word_idx_r + 10'h001;
      end
    end
    // Hardware set wins over a software clear in the same cycle
    flg_nxt = (flg_r & ~stat_clr) | flg_set;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r       <= ST_HUNT;
      idle_cnt_r <= 12'h000;
      bit_cnt_r  <= 5'h00;
      word_idx_r <= 10'h000;
      sh_r       <= 30'h0;
      len_r      <= 10'h000;
      dc_a_r     <= DC_RST;
      dc_b_r     <= DC_RST;
      dc_c_r     <= DC_RST;
      dc_valid_r <= 1'b0;
      flg_r      <= 3'h0;
    end else begin
      st_r       <= st_nxt;
      idle_cnt_r <= idle_cnt_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      word_idx_r <= word_idx_nxt;
      sh_r       <= sh_nxt;
      len_r      <= len_nxt;
      dc_a_r     <= dc_a_nxt;
      dc_b_r     <= dc_b_nxt;
      dc_c_r     <= dc_c_nxt;
      dc_valid_r <= dc_valid_nxt;
      flg_r      <= flg_nxt;
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, wr_val;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [9:0]  ctrl_pos_nxt, gs_a_r, gs_a_nxt, gs_b_r, gs_b_nxt;
  logic [9:0]  gs_c_r, gs_c_nxt;
  logic        wr_go;
  logic [7:0]  wa;
  logic [7:0]  ra;

  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = data[i*8 +: 8];
    return res;
  endfunction

  assign s_axi_awready_out = !aw_hold_r && !bvalid_r;
  assign s_axi_wready_out  = !w_hold_r && !bvalid_r;
  assign s_axi_arready_out = !rvalid_r;
  assign wr_go = aw_hold_r && w_hold_r;
  assign wa    = {awaddr_r[7:2], 2'h0};
  assign ra    = {s_axi_araddr_in[7:2], 2'h0};

  always_comb begin
    aw_hold_nxt = aw_hold_r;  awaddr_nxt = awaddr_r;
    w_hold_nxt  = w_hold_r;   wdata_nxt  = wdata_r;   wstrb_nxt = wstrb_r;
    bvalid_nxt  = bvalid_r;   bresp_nxt  = bresp_r;
    rvalid_nxt  = rvalid_r;   rdata_nxt  = rdata_r;   rresp_nxt = rresp_r;
    ctrl_pos_nxt = ctrl_pos_r;
    gs_a_nxt = gs_a_r;  gs_b_nxt = gs_b_r;  gs_c_nxt = gs_c_r;
    stat_clr = 3'h0;
    wr_val   = 32'h0;
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_hold_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata_in;
      wstrb_nxt  = s_axi_wstrb_in;
    end
    if (bvalid_r && s_axi_bready_in)
      bvalid_nxt = 1'b0;
    if (wr_go) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = RESP_OKAY;
      unique case (wa)
        OFS_CTRL: begin
          wr_val = apply_strb({22'h0, ctrl_pos_r}, wdata_r, wstrb_r);
          ctrl_pos_nxt = wr_val[9:0];
        end
        OFS_GS_A: begin
          wr_val = apply_strb({22'h0, gs_a_r}, wdata_r, wstrb_r);
          gs_a_nxt = wr_val[9:0];
        end
        OFS_GS_B: begin
          wr_val = apply_strb({22'h0, gs_b_r}, wdata_r, wstrb_r);
          gs_b_nxt = wr_val[9:0];
        end
        OFS_GS_C: begin
          wr_val = apply_strb({22'h0, gs_c_r}, wdata_r, wstrb_r);
          gs_c_nxt = wr_val[9:0];
        end
        OFS_DC: ;
        OFS_PKT:
          if (wstrb_r[FLG_LSB / 8])
            stat_clr = wdata_r[FLG_LSB +: 3];
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    if (rvalid_r && s_axi_rready_in)
      rvalid_nxt = 1'b0;
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      unique case (ra)
        OFS_CTRL: rdata_nxt = {22'h0, ctrl_pos_r};
        OFS_GS_A: rdata_nxt = {22'h0, gs_a_r};
        OFS_GS_B: rdata_nxt = {22'h0, gs_b_r};
        OFS_GS_C: rdata_nxt = {22'h0, gs_c_r};
        OFS_DC:   rdata_nxt = {13'h0, dc_valid_r, dc_c_r, dc_b_r, dc_a_r};
        OFS_PKT:  rdata_nxt = {13'h0, flg_r, 6'h00, len_r};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_hold_r <= 1'b0;  awaddr_r <= 8'h00;
      w_hold_r  <= 1'b0;  wdata_r  <= 32'h0;  wstrb_r <= 4'h0;
      bvalid_r  <= 1'b0;  bresp_r  <= RESP_OKAY;
      rvalid_r  <= 1'b0;  rdata_r  <= 32'h0;  rresp_r <= RESP_OKAY;
      ctrl_pos_r <= POS_RST;
      gs_a_r <= GS_RST;  gs_b_r <= GS_RST;  gs_c_r <= GS_RST;
    end else begin
      aw_hold_r <= aw_hold_nxt;  awaddr_r <= awaddr_nxt;
      w_hold_r  <= w_hold_nxt;   wdata_r  <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;   bresp_r  <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;   rdata_r  <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      ctrl_pos_r <= ctrl_pos_nxt;
      gs_a_r <= gs_a_nxt;  gs_b_r <= gs_b_nxt;  gs_c_r <= gs_c_nxt;
    end
  end

  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out  = bresp_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rdata_out  = rdata_r;
  assign s_axi_rresp_out  = rresp_r;

  // ****************************************************************
  // PWM outputs
  // ****************************************************************
  logic [9:0] pwm_cnt_r;
  logic [9:0] pwm_cnt_nxt;

  always_comb pwm_cnt_nxt = pwm_cnt_r + 10'h001;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in)
      pwm_cnt_r <= 10'h000;
    else
      pwm_cnt_r <= pwm_cnt_nxt;
  end

  dcrx_pwm u_pwm_a (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .cnt_in(pwm_cnt_r), .gray_in(gs_a_r), .dc_in(dc_a_r),
    .on_out(sink_output_a_out));
  dcrx_pwm u_pwm_b (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .cnt_in(pwm_cnt_r), .gray_in(gs_b_r), .dc_in(dc_b_r),
    .on_out(sink_output_b_out));
  dcrx_pwm u_pwm_c (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .cnt_in(pwm_cnt_r), .gray_in(gs_c_r), .dc_in(dc_c_r),
    .on_out(sink_output_c_out));

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  AST_IDLE_ARM: assert property (
    idle_hit |=> st_r == ST_PRE && bit_cnt_r == 5'h00)
    else $error("idle span did not arm preamble");
  AST_PRE_LEN: assert property (
    st_r == ST_PRE && bit_evt && bit_cnt_r != LAST_BIT && !idle_hit
    |=> st_r == ST_PRE)
    else $error("preamble left before 30 bits");
  AST_HDR_BAD: assert property (
    word_done && st_r == ST_PRE && !hdr_ok && !idle_hit
    |=> st_r == ST_SKIP && flg_r[0])
    else $error("bad header accepted");
  AST_PAR_LOW: assert property (
    word_done && st_r == ST_PRE && !plow_ok && !idle_hit
    |=> st_r == ST_SKIP && flg_r[1])
    else $error("field parity error accepted");
  AST_PAR_TOP: assert property (
    word_done && st_r == ST_PRE && !p3_ok && !idle_hit
    |=> st_r != ST_DATA)
    else $error("top parity error accepted");
  AST_LEN_TAKEN: assert property (
    word_done && st_r == ST_PRE && hdr_ok && plow_ok && p3_ok && !idle_hit
    |=> st_r == ST_DATA && len_r == $past(word_w[9:0]))
    else $error("chain length not taken");
  AST_CHK_HOLD: assert property (
    word_done && own_w && !chk_ok |=> $stable(dc_a_r) && $stable(dc_b_r)
    && $stable(dc_c_r) && flg_r[2])
    else $error("data latched despite check bits");
  AST_LATCH_ALL: assert property (
    word_done && own_w && chk_ok && !idle_hit
    |=> dc_c_r == $past(word_w[25:20]) && dc_b_r == $past(word_w[15:10])
    && dc_a_r == $past(word_w[5:0]))
    else $error("correction values not latched together");
  AST_OWN_ONLY: assert property (
    !$stable(dc_a_r) || !$stable(dc_b_r) || !$stable(dc_c_r)
    |-> $past(word_done && own_w && chk_ok))
    else $error("correction changed outside own word");

endmodule // dcrx_top

// ### verification/dcrx_ctl_model.sv
// Behavioural system controller driving the two-wire link.
// Assumes the receiver samples data on the rising serial clock edge.
`timescale 1ns/1ps
module dcrx_ctl_model (
  // Link
  output logic serial_clock_out,
  output logic serial_data_out
);
  initial begin
    serial_clock_out = 1'b0;
    serial_data_out  = 1'b0;
  end

  // ****************************************************************
  // Framing
  // ****************************************************************
  // Clock stopped and both lines low, with margin over the minimum
  task automatic idle();
    serial_clock_out = 1'b0;
    serial_data_out  = 1'b0;
    #(180 * 64);
  endtask

  // One 30-bit unit, MSB first; data moves on the falling edge
  task automatic word(input logic [29:0] w);
    for (int i = 29; i >= 0; i--) begin
      serial_data_out = w[i];
      #32 serial_clock_out = 1'b1;
      #32 serial_clock_out = 1'b0;
    end
  endtask
endmodule // dcrx_ctl_model

// ### verification/dot_correction_6bit_packet_rx_tb_top.sv
// Self-checking bench: AXI4-Lite tasks plus packets from the controller.
// Assumes the controller model drives the serial link pins.
`timescale 1ns/1ps
module dot_correction_6bit_packet_rx_tb_top
  import dcrx_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, sck, sda;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  wire  [2:0]  sink;
  logic [29:0] w, p;
  int          cnt [3];
  int          errors = 0;
  int          n_checks = 0;

  always #2.5 clk = ~clk;

  dcrx_top dut_u (
    .ref_clk_in(clk), .rst_in(rst),
    .serial_clock_in(sck), .serial_data_in(sda),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .sink_output_a_out(sink[0]),
    .sink_output_b_out(sink[1]), .sink_output_c_out(sink[2])
  );

  dcrx_ctl_model ctl_u (.serial_clock_out(sck), .serial_data_out(sda));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Handshakes judged on the low phase, released after the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er = RESP_OKAY);
    logic ta, tw, tb;
    logic [1:0] r;
    tb = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r  = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("bresp", 32'(r), 32'(er));
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    tr = 1'b0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!tr) begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk("rdata", d, e);
    chk("rresp", 32'(r), 32'(er));
  endtask

  function automatic logic [29:0] pre(input logic [5:0] h,
                                      input logic [9:0] l);
    logic [2:0] q;
    q = {^h, 1'b0, ^l};
    return {h, ^q, q, 10'h000, l};
  endfunction

  function automatic logic [29:0] dw(input logic [5:0] c, b, a);
    return {4'h0, c, 4'h0, b, 4'h0, a};
  endfunction

  task automatic pkt(input logic [29:0] pr, w0, w1);
    ctl_u.idle();
    ctl_u.word(pr);
    ctl_u.word(w0);
    ctl_u.word(w1);
    repeat (20) @(posedge clk);
  endtask

  task automatic report_and_stop();
    $display("Checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rc(OFS_DC, 32'h3ffff, RESP_OKAY);
    rc(8'h18, 32'h0, RESP_SLVERR);
    wr(8'h18, 32'h5, 4'hf, RESP_SLVERR);
    wr(OFS_CTRL, 32'h1, 4'hf);
    wr(OFS_GS_A, 32'h200, 4'hf);
    wr(OFS_GS_B, 32'h3ff, 4'hf);
    wr(OFS_GS_C, 32'h100, 4'hf);
    pkt(pre(HDR_6BIT, 10'h001), dw(6'h05, 6'h2a, 6'h11),
        dw(6'h3f, 6'h3f, 6'h3f));
    rc(OFS_DC, 32'h45a91, RESP_OKAY);
    rc(OFS_PKT, 32'h1, RESP_OKAY);
    // Whole period window, so the counter phase does not matter
    repeat (2100) @(posedge clk);
    cnt = '{0, 0, 0};
    repeat (1024) begin
      @(negedge clk);
      for (int i = 0; i < 3; i++) cnt[i] += sink[i];
    end
    chk("duty_a", 32'(cnt[0]), 32'h90);
    chk("duty_b", 32'(cnt[1]), 32'h2af);
    chk("duty_c", 32'(cnt[2]), 32'h18);
    for (int k = 0; k < 3; k++) begin
      w = dw(6'h01, 6'h01, 6'h01) | (30'h1 << (CHK_A_LSB + 10 * k));
      pkt(pre(HDR_6BIT, 10'h001), w, 30'h0);
      rc(OFS_DC, 32'h45a91, RESP_OKAY);
      rc(OFS_PKT, 32'h40001, RESP_OKAY);
      wr(OFS_PKT, 32'h40000, 4'h4);
    end
    for (int k = 0; k < 2; k++) begin
      p = k ? pre(HDR_6BIT, 10'h001) ^ 30'h100000 : pre(6'h33, 10'h001);
      pkt(p, dw(6'h01, 6'h01, 6'h01), dw(6'h01, 6'h01, 6'h01));
      rc(OFS_DC, 32'h45a91, RESP_OKAY);
      rc(OFS_PKT, (32'h10000 << k) | 32'h1, RESP_OKAY);
      wr(OFS_PKT, 32'h30000, 4'h4);
    end
    rc(OFS_PKT, 32'h1, RESP_OKAY);
    wr(OFS_CTRL, 32'h0, 4'hf);
    pkt(pre(HDR_6BIT, 10'h001), dw(6'h3f, 6'h3f, 6'h3f),
        dw(6'h02, 6'h03, 6'h04));
    rc(OFS_DC, 32'h420c4, RESP_OKAY);
    // No idle prefix: the chain stays closed, so this packet is ignored
    ctl_u.word(pre(HDR_6BIT, 10'h001));
    ctl_u.word(dw(6'h3f, 6'h3f, 6'h3f));
    ctl_u.word(dw(6'h3f, 6'h3f, 6'h3f));
    repeat (20) @(posedge clk);
    rc(OFS_DC, 32'h420c4, RESP_OKAY);
    report_and_stop();
  end

  initial begin
    #400000;
    errors++;
    report_and_stop();
  end
endmodule // dot_correction_6bit_packet_rx_tb_top
